// ==== design/occtl_pkg.sv ====
// Constants for the output compare channel control block
package occtl_pkg;
	localparam int          DATA_W        = 32;
	localparam int          ADDR_W        = 8;
	// Register byte addresses
	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_IRQ_STAT = 8'h04;
	localparam logic [7:0]  ADDR_IRQ_MASK = 8'h08;
	localparam logic [7:0]  ADDR_PRI      = 8'h0c;
	localparam logic [7:0]  ADDR_SEC      = 8'h10;
	localparam logic [7:0]  ADDR_STATUS   = 8'h14;
	// Control register fields
	localparam int          BIT_IDLE_STOP = 13;
	localparam int          TBS_LSB       = 10;
	localparam int          BIT_FLT_B_EN  = 8;
	localparam int          BIT_FLT_A_EN  = 7;
	localparam int          BIT_FLT_B     = 5;
	localparam int          BIT_FLT_A     = 4;
	localparam int          BIT_TRIG      = 3;
	localparam int          MODE_LSB      = 0;
	// Writable bits of the control register; unimplemented bits read zero
	localparam logic [15:0] CTRL_WMASK    = 16'h3dbf;
	localparam logic [15:0] CTRL_RESET    = 16'h0000;
	localparam logic [1:0]  RESP_OKAY     = 2'b00;
	localparam logic [1:0]  RESP_SLVERR   = 2'b10;
	// Interrupt status bits
	localparam int          IRQ_FLT_A     = 0;
	localparam int          IRQ_FLT_B     = 1;
	// Mode codes treated as PWM for compare double buffering
	localparam logic [2:0]  MODE_PWM_A    = 3'h6;
	localparam logic [2:0]  MODE_PWM_B    = 3'h7;

	typedef enum logic [2:0] {
		TB_TIMER2  = 3'b000,
		TB_TIMER3  = 3'b001,
		TB_TIMER4  = 3'b010,
		TB_RSVD3   = 3'b011,
		TB_TIMER1  = 3'b100,
		TB_TRIGGEN = 3'b101,
		TB_RSVD6   = 3'b110,
		TB_PERIPH  = 3'b111
	} time_base_t;
endpackage

// ==== design/occtl_sync.sv ====
// Two-stage synchroniser for a vector of pin levels
`timescale 1ns/1ps
module occtl_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_arst_n,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_state_t;

	sync_state_t st_q;
	sync_state_t st_d;

	always_comb begin
		st_d    = st_q;
		st_d.s1 = i_d;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_q = st_q.s2;
endmodule // occtl_sync

// ==== design/output_compare_control.sv ====
// Output compare channel control register, time base select and fault capture
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module output_compare_control
	import occtl_pkg::*;
#(
	parameter int CHANNEL = 1,
	parameter int CMP_W   = 16
) (
	input  wire logic                       I_CLK_SYS,
	input  wire logic                       I_ARST_N,
	input  wire logic [occtl_pkg::ADDR_W-1:0] S_AXI_AWADDR,
	input  wire logic                       S_AXI_AWVALID,
	output logic                            S_AXI_AWREADY,
	input  wire logic [occtl_pkg::DATA_W-1:0] S_AXI_WDATA,
	input  wire logic [3:0]                 S_AXI_WSTRB,
	input  wire logic                       S_AXI_WVALID,
	output logic                            S_AXI_WREADY,
	output logic [1:0]                      S_AXI_BRESP,
	output logic                            S_AXI_BVALID,
	input  wire logic                       S_AXI_BREADY,
	input  wire logic [occtl_pkg::ADDR_W-1:0] S_AXI_ARADDR,
	input  wire logic                       S_AXI_ARVALID,
	output logic                            S_AXI_ARREADY,
	output logic [occtl_pkg::DATA_W-1:0]    S_AXI_RDATA,
	output logic [1:0]                      S_AXI_RRESP,
	output logic                            S_AXI_RVALID,
	input  wire logic                       S_AXI_RREADY,
	input  wire logic                       i_cpu_idle,
	input  wire logic                       i_period_end,
	input  wire logic                       i_timer_one_clock,
	input  wire logic                       i_timer_two_clock,
	input  wire logic                       i_timer_three_clock,
	input  wire logic                       i_timer_four_clock,
	input  wire logic                       i_peripheral_clock,
	input  wire logic [7:0]                 i_trigger_generator_output,
	input  wire logic                       i_fault_a_pin,
	input  wire logic                       i_fault_b_pin,
	output logic                            o_channel_tick,
	output logic                            o_channel_run,
	output logic                            o_fault_active,
	output logic [CMP_W-1:0]                o_primary_compare_value,
	output logic [CMP_W-1:0]                o_secondary_compare_value,
	output logic                            o_irq
);
	import occtl_pkg::*;

	initial begin
		if (CHANNEL < 1 || CHANNEL > 4) begin
			$error("CHANNEL must be 1 to 4");
		end
		if (CMP_W < 1 || CMP_W > 16) begin
			$error("CMP_W must be 1 to 16");
		end
	end

	// Trigger generator output index serving this channel
	localparam int TRIG_BASE = 3;
	localparam int TRIG_IDX  = CHANNEL + TRIG_BASE;

	typedef struct packed {
		logic              aw_have;
		logic [ADDR_W-1:0] aw_addr;
		logic              w_have;
		logic [DATA_W-1:0] w_data;
		logic [3:0]        w_strb;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
		logic [15:0]       ctrl;
		logic [1:0]        irq_stat;
		logic [1:0]        irq_mask;
		logic [CMP_W-1:0]  pri_buf;
		logic [CMP_W-1:0]  sec_buf;
		logic [CMP_W-1:0]  pri_act;
		logic [CMP_W-1:0]  sec_act;
		logic              clk_src_prev;
		logic              tick;
		logic              run;
		logic              fault;
		logic              irq;
	} state_t;

	state_t st_q;
	state_t st_d;

	logic [8:0] pins_raw;
	logic [8:0] pins_s;

	assign pins_raw = {i_trigger_generator_output[TRIG_IDX], i_timer_one_clock,
		i_timer_two_clock, i_timer_three_clock, i_timer_four_clock,
		i_peripheral_clock, i_fault_a_pin, i_fault_b_pin, 1'b0};

	// Every pin level passes two flops before any decision uses it
	occtl_sync #(
		.W (9)
	) u_sync (
		.i_clk    (I_CLK_SYS),
		.i_arst_n (I_ARST_N),
		.i_d      (pins_raw),
		.o_q      (pins_s)
	);

	// Byte-lane merge of a write into a register
	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
		input logic [DATA_W-1:0] wd, input logic [3:0] strb);
		logic [DATA_W-1:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		return (a == ADDR_CTRL) || (a == ADDR_IRQ_STAT) || (a == ADDR_IRQ_MASK) ||
			(a == ADDR_PRI) || (a == ADDR_SEC) || (a == ADDR_STATUS);
	endfunction

	logic              src_lvl;
	logic              wr_fire;
	logic              pwm_mode;
	logic              fa_evt;
	logic              fb_evt;
	logic [DATA_W-1:0] wv;
	logic [DATA_W-1:0] ctrl32;

	always_comb begin
		st_d    = st_q;
		src_lvl = 1'b0;
		wv      = '0;
		ctrl32  = {16'h0000, st_q.ctrl};
		case (time_base_t'(st_q.ctrl[TBS_LSB +: 3]))
			TB_PERIPH:  src_lvl = pins_s[3];
			TB_TRIGGEN: src_lvl = pins_s[8];
			TB_TIMER1:  src_lvl = pins_s[7];
			TB_TIMER4:  src_lvl = pins_s[4];
			TB_TIMER3:  src_lvl = pins_s[5];
			TB_TIMER2:  src_lvl = pins_s[6];
			default:    src_lvl = 1'b0;      // Reserved codes give no clock
		endcase
		st_d.clk_src_prev = src_lvl;
		// Halt in idle only when the stop bit asks for it
		st_d.run  = !(st_q.ctrl[BIT_IDLE_STOP] && i_cpu_idle);
		st_d.tick = st_d.run && src_lvl && !st_q.clk_src_prev;
		fa_evt = st_q.ctrl[BIT_FLT_A_EN] && pins_s[2];
		fb_evt = st_q.ctrl[BIT_FLT_B_EN] && pins_s[1];
		pwm_mode = (st_q.ctrl[MODE_LSB +: 3] == MODE_PWM_A) ||
			(st_q.ctrl[MODE_LSB +: 3] == MODE_PWM_B);

		// Write channel: address and data taken in either order
		if (S_AXI_AWVALID && st_q.awready) begin
			st_d.aw_have = 1'b1;
			st_d.aw_addr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && st_q.wready) begin
			st_d.w_have = 1'b1;
			st_d.w_data = S_AXI_WDATA;
			st_d.w_strb = S_AXI_WSTRB;
		end
		st_d.awready = !st_d.aw_have && !st_q.bvalid;
		st_d.wready  = !st_d.w_have && !st_q.bvalid;
		wr_fire = st_q.aw_have && st_q.w_have && !st_q.bvalid;
		if (wr_fire) begin
			st_d.aw_have = 1'b0;
			st_d.w_have  = 1'b0;
			st_d.awready = 1'b0;
			st_d.wready  = 1'b0;
			st_d.bvalid  = 1'b1;
			st_d.bresp   = is_mapped(st_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
			case (st_q.aw_addr)
				ADDR_CTRL: begin
					wv = merge(ctrl32, st_q.w_data, st_q.w_strb);
					// Flags, mode and trigger bit are plain storage
					st_d.ctrl = wv[15:0] & CTRL_WMASK;
				end
				ADDR_IRQ_STAT: begin
					st_d.irq_stat = st_q.irq_stat & ~st_q.w_data[1:0];
				end
				ADDR_IRQ_MASK: begin
					st_d.irq_mask = st_q.w_data[1:0];
				end
				ADDR_PRI: begin
					wv = merge({{(DATA_W-CMP_W){1'b0}}, st_q.pri_buf}, st_q.w_data, st_q.w_strb);
					st_d.pri_buf = wv[CMP_W-1:0];
				end
				ADDR_SEC: begin
					wv = merge({{(DATA_W-CMP_W){1'b0}}, st_q.sec_buf}, st_q.w_data, st_q.w_strb);
					st_d.sec_buf = wv[CMP_W-1:0];
				end
				default: begin
				end
			endcase
		end
		if (st_q.bvalid && S_AXI_BREADY) begin
			st_d.bvalid  = 1'b0;
			st_d.awready = 1'b1;
			st_d.wready  = 1'b1;
		end

		// Read channel
		if (S_AXI_ARVALID && st_q.arready) begin
			st_d.arready = 1'b0;
			st_d.rvalid  = 1'b1;
			st_d.rresp   = is_mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
			case (S_AXI_ARADDR)
				ADDR_CTRL:     st_d.rdata = ctrl32;
				ADDR_IRQ_STAT: st_d.rdata = {30'h0, st_q.irq_stat};
				ADDR_IRQ_MASK: st_d.rdata = {30'h0, st_q.irq_mask};
				ADDR_PRI:      st_d.rdata = {{(DATA_W-CMP_W){1'b0}}, st_q.pri_buf};
				ADDR_SEC:      st_d.rdata = {{(DATA_W-CMP_W){1'b0}}, st_q.sec_buf};
				ADDR_STATUS:   st_d.rdata = {29'h0, st_q.fault, st_q.run, st_q.tick};
				default:       st_d.rdata = '0;
			endcase
		end
		if (st_q.rvalid && S_AXI_RREADY) begin
			st_d.rvalid  = 1'b0;
			st_d.arready = 1'b1;
		end

		// Hardware set wins over a software clear in the same cycle
		if (fa_evt) begin
			st_d.ctrl[BIT_FLT_A]    = 1'b1;
			st_d.irq_stat[IRQ_FLT_A] = 1'b1;
		end
		if (fb_evt) begin
			st_d.ctrl[BIT_FLT_B]    = 1'b1;
			st_d.irq_stat[IRQ_FLT_B] = 1'b1;
		end

		// PWM mode loads shadows at the period end, other modes at once
		if (!pwm_mode || i_period_end) begin
			st_d.pri_act = st_d.pri_buf;
			st_d.sec_act = st_d.sec_buf;
		end
		st_d.fault = st_d.ctrl[BIT_FLT_A] || st_d.ctrl[BIT_FLT_B];
		st_d.irq   = |(st_d.irq_stat & st_d.irq_mask);
	end

	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			st_q         <= '0;
			st_q.ctrl    <= CTRL_RESET;
			st_q.awready <= 1'b1;
			st_q.wready  <= 1'b1;
			st_q.arready <= 1'b1;
			st_q.run     <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign S_AXI_AWREADY             = st_q.awready;
	assign S_AXI_WREADY              = st_q.wready;
	assign S_AXI_BVALID              = st_q.bvalid;
	assign S_AXI_BRESP               = st_q.bresp;
	assign S_AXI_ARREADY             = st_q.arready;
	assign S_AXI_RVALID              = st_q.rvalid;
	assign S_AXI_RDATA               = st_q.rdata;
	assign S_AXI_RRESP               = st_q.rresp;
	assign o_channel_tick            = st_q.tick;
	assign o_channel_run             = st_q.run;
	assign o_fault_active            = st_q.fault;
	assign o_primary_compare_value   = st_q.pri_act;
	assign o_secondary_compare_value = st_q.sec_act;
	assign o_irq                     = st_q.irq;
endmodule // output_compare_control

// ==== tb/occtl_checker.sv ====
// Port-level assertions for the output compare control block
`timescale 1ns/1ps
module occtl_checker #(
	parameter int CMP_W = 16
) (
	input wire logic		I_CLK_SYS,
	input wire logic		I_ARST_N,
	input wire logic		S_AXI_WVALID,
	input wire logic		S_AXI_WREADY,
	input wire logic		i_cpu_idle,
	input wire logic		i_period_end,
	input wire logic		i_fault_a_pin,
	input wire logic		i_fault_b_pin,
	input wire logic		o_channel_tick,
	input wire logic		o_channel_run,
	input wire logic		o_fault_active,
	input wire logic [CMP_W-1:0]	o_primary_compare_value,
	input wire logic		o_irq
);
	// Short histories of the causes, so late effects still find them
	logic [4:0] flt_q, wr_q, idl_q, pe_q;
	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			flt_q <= '0;
			wr_q <= '0;
			idl_q <= '0;
			pe_q <= '0;
		end else begin
			flt_q <= {flt_q[3:0], i_fault_a_pin | i_fault_b_pin};
			wr_q <= {wr_q[3:0], S_AXI_WVALID & S_AXI_WREADY};
			idl_q <= {idl_q[3:0], i_cpu_idle};
			pe_q <= {pe_q[3:0], i_period_end};
		end
	end
	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_ARST_N);
	AST_RUN_NEEDS_IDLE: assert property ($fell(o_channel_run) |-> |idl_q)
		else $error("run dropped without idle");
	AST_RUN_AWAKE: assert property (!i_cpu_idle [*2] |-> o_channel_run)
		else $error("run low while awake");
	AST_HALT_NO_TICK: assert property (!o_channel_run |-> !o_channel_tick)
		else $error("tick while halted");
	AST_TICK_PULSE: assert property (o_channel_tick |=> !o_channel_tick)
		else $error("tick longer than one cycle");
	AST_FAULT_CAUSE: assert property ($rose(o_fault_active) |-> |flt_q || |wr_q)
		else $error("fault without pin or write");
	AST_FLAG_STICKY: assert property ($fell(o_fault_active) |-> |wr_q)
		else $error("fault flag dropped by itself");
	AST_IRQ_CAUSE: assert property ($rose(o_irq) |-> |flt_q || |wr_q)
		else $error("irq without cause");
	AST_CMP_CAUSE: assert property ($changed(o_primary_compare_value) |-> |wr_q || |pe_q)
		else $error("compare value changed alone");
	cover property (o_channel_tick);
	cover property ($fell(o_channel_run));
	cover property ($rose(o_irq));
endmodule // occtl_checker

// ==== tb/occtl_partner.sv ====
// Far-side model: timer clocks, trigger outputs and fault pins
`timescale 1ns/1ps
module occtl_partner (
	input wire logic		i_clk,
	input wire logic		i_arst_n,
	input wire logic [1:0]	i_fault_req,
	output logic		o_timer_one_clock,
	output logic		o_timer_two_clock,
	output logic		o_timer_three_clock,
	output logic		o_timer_four_clock,
	output logic		o_peripheral_clock,
	output logic [7:0]	o_trigger_generator_output,
	output logic		o_fault_a_pin,
	output logic		o_fault_b_pin
);
	int cnt_q;
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt_q <= 0;
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end
	// Distinct rates, so a wrong source shows as a wrong tick count
	assign o_timer_one_clock = (cnt_q % 6) < 3;
	assign o_timer_two_clock = (cnt_q % 8) < 4;
	assign o_timer_three_clock = (cnt_q % 10) < 5;
	assign o_timer_four_clock = (cnt_q % 12) < 6;
	assign o_peripheral_clock = (cnt_q % 4) < 2;
	// Only output 4 runs: channel 1 must pick that one
	assign o_trigger_generator_output = {3'h0, (cnt_q % 14) < 7, 4'h0};
	assign o_fault_a_pin = i_fault_req[0];
	assign o_fault_b_pin = i_fault_req[1];
endmodule // occtl_partner

// ==== tb/output_compare_control_tb.sv ====
// Self-checking bench for the output compare control block
`timescale 1ns/1ps
module output_compare_control_tb;
	import occtl_pkg::*;
	logic I_CLK_SYS = 1'h0, I_ARST_N = 1'h0, i_cpu_idle = 1'h0, i_period_end = 1'h0;
	logic S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
	logic S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
	logic [ADDR_W-1:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
	logic [DATA_W-1:0] S_AXI_WDATA = '0, S_AXI_RDATA;
	logic [3:0] S_AXI_WSTRB = 4'hf;
	logic [1:0] fault_req = 2'h0, S_AXI_BRESP, S_AXI_RRESP;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic o_channel_tick, o_channel_run, o_fault_active, o_irq, i_fault_a_pin, i_fault_b_pin;
	logic i_timer_one_clock, i_timer_two_clock, i_timer_three_clock, i_timer_four_clock;
	logic i_peripheral_clock;
	logic [7:0] i_trigger_generator_output;
	logic [15:0] o_primary_compare_value, o_secondary_compare_value;
	int err_total = 0, checked = 0;
	// Response code of the last write, so bus answers are judged too
	logic [1:0] last_bresp = 2'h0;
	always #20 I_CLK_SYS = ~I_CLK_SYS;
	output_compare_control u_dut (.*);
	occtl_partner u_far (.i_clk(I_CLK_SYS), .i_arst_n(I_ARST_N), .i_fault_req(fault_req),
		.o_timer_one_clock(i_timer_one_clock), .o_timer_two_clock(i_timer_two_clock),
		.o_timer_three_clock(i_timer_three_clock), .o_timer_four_clock(i_timer_four_clock),
		.o_peripheral_clock(i_peripheral_clock), .o_fault_a_pin(i_fault_a_pin),
		.o_trigger_generator_output(i_trigger_generator_output), .o_fault_b_pin(i_fault_b_pin));
	task automatic conclude();
		$display("checked %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic chk_rng(input string s, input int lo, hi, g);
		checked++;
		if (g < lo || g > hi) begin
			err_total++;
			$display("ERROR %s expected %0d..%0d seen %0d", s, lo, hi, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge I_CLK_SYS);
	endtask
	task automatic ticks(input int n, output int c);
		c = 0;
		repeat (n) begin
			@(posedge I_CLK_SYS);
			if (o_channel_tick === 1'h1) c++;
		end
	endtask
	// The master never assumes a latency: it waits under a bound
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= 1'h1;
		S_AXI_WVALID <= 1'h1;
		S_AXI_BREADY <= 1'h1;
		for (n = 0; n < 20; n++) begin
			@(posedge I_CLK_SYS);
			if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'h0;
			if (S_AXI_WREADY) S_AXI_WVALID <= 1'h0;
			if (S_AXI_BVALID) break;
		end
		if (n == 20) begin
			err_total++;
			$display("ERROR write expected response seen timeout");
			conclude();
		end
		last_bresp = S_AXI_BRESP;
		S_AXI_BREADY <= 1'h0;
		@(posedge I_CLK_SYS);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'h1;
		S_AXI_RREADY <= 1'h1;
		for (n = 0; n < 20; n++) begin
			@(posedge I_CLK_SYS);
			if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'h0;
			if (S_AXI_RVALID) break;
		end
		if (n == 20) begin
			err_total++;
			$display("ERROR read expected data seen timeout");
			conclude();
		end
		d = S_AXI_RDATA;
		r = S_AXI_RRESP;
		S_AXI_RREADY <= 1'h0;
		@(posedge I_CLK_SYS);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string s);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(s, e, d);
	endtask
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0] r;
		rd_chk(ADDR_CTRL, {16'h0, CTRL_RESET}, "ctrl reset");
		rd_chk(ADDR_IRQ_MASK, 32'h0, "mask reset");
		rd(8'h40, d, r);
		chk("unmapped data", 32'h0, d);
		chk("unmapped resp", RESP_SLVERR, r);
		wr(8'h40, 32'hffff_ffff);
		chk("unmapped bresp", RESP_SLVERR, last_bresp);
		wr(ADDR_CTRL, 32'hffff_ffff);
		chk("ctrl bresp", RESP_OKAY, last_bresp);
		rd_chk(ADDR_CTRL, {16'h0, CTRL_WMASK}, "ctrl ones");
		wr(ADDR_CTRL, 32'h0);
		rd_chk(ADDR_CTRL, 32'h0, "ctrl cleared");
		wr(ADDR_IRQ_STAT, 32'h3);
		$display("test regs done");
	endtask
	task automatic t_tbase();
		int exp [8] = '{30, 24, 20, 0, 40, 17, 0, 60};
		int c;
		for (int k = 0; k < 8; k++) begin
			wr(ADDR_CTRL, 32'(k) << TBS_LSB);
			cyc(8);
			ticks(240, c);
			chk_rng("ticks", exp[k] - 1, exp[k] + (exp[k] != 0), c);
		end
		$display("test time base done");
	endtask
	task automatic t_idle();
		int c;
		wr(ADDR_CTRL, 32'h3c00);
		i_cpu_idle <= 1'h1;
		cyc(4);
		chk("run halted", 32'h0, o_channel_run);
		ticks(40, c);
		chk_rng("halted ticks", 0, 0, c);
		wr(ADDR_CTRL, 32'h1c00);
		cyc(4);
		chk("run idle", 32'h1, o_channel_run);
		ticks(40, c);
		chk_rng("idle ticks", 9, 11, c);
		i_cpu_idle <= 1'h0;
		$display("test idle done");
	endtask
	task automatic t_fault(input int k);
		logic [31:0] en, fl, ir;
		en = 32'h80 << k;
		fl = 32'h10 << k;
		ir = 32'h1 << k;
		wr(ADDR_IRQ_MASK, 32'h0);
		wr(ADDR_CTRL, 32'h180 ^ en);
		fault_req[k] <= 1'h1;
		cyc(8);
		rd_chk(ADDR_CTRL, 32'h180 ^ en, "pin ignored");
		wr(ADDR_CTRL, en);
		cyc(8);
		rd_chk(ADDR_CTRL, en | fl, "flag set");
		rd_chk(ADDR_IRQ_STAT, ir, "irq status");
		chk("masked irq", 32'h0, o_irq);
		wr(ADDR_IRQ_MASK, ir);
		cyc(2);
		chk("irq", 32'h1, o_irq);
		fault_req[k] <= 1'h0;
		cyc(6);
		rd_chk(ADDR_CTRL, en | fl, "flag sticky");
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_IRQ_STAT, ir);
		cyc(2);
		chk("cleared", 32'h0, {o_irq, o_fault_active});
		$display("test fault %0d done", k);
	endtask
	task automatic t_cmp();
		logic [31:0] p;
		p = 32'h1234;
		wr(ADDR_PRI, p);
		wr(ADDR_SEC, 32'h0abc);
		cyc(2);
		chk("pri direct", p, o_primary_compare_value);
		chk("sec direct", 32'h0abc, o_secondary_compare_value);
		for (int m = 6; m < 8; m++) begin
			wr(ADDR_CTRL, 32'(m));
			wr(ADDR_PRI, 32'h5600 + m);
			wr(ADDR_SEC, 32'h9a00 + m);
			cyc(4);
			chk("pri held", p, o_primary_compare_value);
			rd_chk(ADDR_PRI, 32'h5600 + m, "pri written");
			i_period_end <= 1'h1;
			@(posedge I_CLK_SYS);
			i_period_end <= 1'h0;
			cyc(2);
			p = 32'h5600 + m;
			chk("pri loaded", p, o_primary_compare_value);
			chk("sec loaded", 32'h9a00 + m, o_secondary_compare_value);
		end
		wr(ADDR_CTRL, 32'h0);
		$display("test compare done");
	endtask
	initial begin
		cyc(20);
		I_ARST_N <= 1'h1;
		@(posedge I_CLK_SYS);
		t_regs();
		t_tbase();
		t_idle();
		t_fault(0);
		t_fault(1);
		t_cmp();
		conclude();
	end
endmodule // output_compare_control_tb
bind output_compare_control occtl_checker #(.CMP_W(CMP_W)) u_chk (.*);
